// file: hdl/ohci_periodic_and_lowspeed_gate.sv
// frame gate: periodic priority point and low-speed commit check per function
// assumes a decoder that strips the window base and hands offset, function and data
// assumes bit_tick_in pulses once per full-speed bit time, synchronous to sys_clk_in
`timescale 1ns/1ns

//
// Contract
// RULE_01 - periodic start value is 14 bits at 13..0, upper bits reserved.
// RULE_02 - hardware reset clears the periodic start value.
// RULE_03 - driver loads periodic start at init, about ten percent of interval.
// RULE_04 - at or below the start point, periodic work outranks control and bulk.
// RULE_05 - a control or bulk transaction in flight finishes before periodic starts.
// RULE_06 - a low-speed commit limit guards short low-speed packets before frame end.
// RULE_07 - remaining time is compared against the 12-bit limit before low-speed start.
// RULE_08 - low-speed starts only if remaining time is at least the limit.
// RULE_09 - driver picks the limit allowing for low-speed overhead.
// RULE_10 - the limit is meant to stay fixed though its bits are writable.
// RULE_11 - software writes reserved bits with their reset value.
// RULE_12 - each function decodes its own registers at offsets 40h and 44h.
// RULE_13 - frame count advances each time remaining time is reloaded.
// RULE_14 - remaining time counts bit times down and reloads at frame boundary.
module ohci_periodic_and_lowspeed_gate
   import frame_gate_pkg::*;
#(
   parameter int functions = num_functions
) (
   // clock, reset, enable
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   // register access
   input wire reg_req_t reg_req_in,
   output logic [31:0] reg_rdata_out,
   output logic reg_hit_out,
   // frame timing
   input wire logic bit_tick_in,
   input wire frame_in_t [functions-1:0] frame_in,
   output frame_out_t [functions-1:0] frame_out
);

   ////////////////////////////////////////////////////////////////////////////
   // per function registers and frame timing

   logic [functions-1:0][31:0] rd_word;
   logic [functions-1:0] rd_hit;

   genvar f;
   generate
      for (f = 0; f < functions; f++) begin : g_func
         logic [psp_width-1:0] psp_q;
         logic [lsc_width-1:0] lsc_q;
         logic [remaining_width-1:0] remaining_q;
         logic [frame_count_width-1:0] frame_q;
         logic due_q;
         logic grant_q;
         logic mine;
         logic hit_psp;
         logic hit_lsc;
         logic reload;
         logic reached;

         assign mine = reg_req_in.sel && (reg_req_in.func == 1'(f));
         // window decode
         always_comb begin
            hit_psp = 1'b0;
            hit_lsc = 1'b0;
            if (mine && reg_req_in.offset == periodic_start_point_offset) begin // RULE_12
               hit_psp = 1'b1;
            end else if (mine && reg_req_in.offset == low_speed_commit_limit_offset) begin
               hit_lsc = 1'b1;
            end
         end

         // reserved bits are not stored, so they always read back as zero
         always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               psp_q <= periodic_start_point_reset; // RULE_02
            end else if (clk_en_in && hit_psp && reg_req_in.write) begin
               psp_q <= reg_req_in.wdata[psp_width-1:0]; // RULE_01
            end
         end

         // writable so a driver can tune it, though in practice it stays fixed
         always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               lsc_q <= low_speed_commit_field_reset; // RULE_06
            end else if (clk_en_in && hit_lsc && reg_req_in.write) begin
               lsc_q <= reg_req_in.wdata[lsc_width-1:0]; // RULE_10
            end
         end

         always_comb begin
            rd_hit[f] = hit_psp | hit_lsc;
            rd_word[f] = 32'h0000_0000;
            if (hit_psp) begin
               rd_word[f] = {{(32-psp_width){1'b0}}, psp_q};
            end else if (hit_lsc) begin
               rd_word[f] = {{(32-lsc_width){1'b0}}, lsc_q};
            end
         end

         assign reload = frame_in[f].running && bit_tick_in && (remaining_q == remaining_reset);
         // a stopped function clears remaining to zero so the first running tick loads a full frame
         always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               remaining_q <= remaining_reset;
            end else if (clk_en_in) begin
               if (!frame_in[f].running) begin
                  remaining_q <= remaining_reset;
               end else if (reload) begin
                  remaining_q <= frame_in[f].interval_setting; // RULE_14
               end else if (bit_tick_in) begin
                  remaining_q <= remaining_q - 14'h0001; // RULE_14
               end
            end
         end

         always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               frame_q <= frame_count_reset;
            end else if (clk_en_in && reload) begin
               frame_q <= frame_q + 16'h0001; // RULE_13
            end
         end

         assign reached = frame_in[f].running && (remaining_q <= psp_q);
         // priority holds from the start point until the frame boundary
         always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               due_q <= 1'b0;
            end else if (clk_en_in) begin
               if (reload || !frame_in[f].running) begin
                  due_q <= 1'b0;
               end else if (reached) begin
                  due_q <= 1'b1; // RULE_04
               end
            end
         end

         // grant waits for the async transaction in flight, never cuts it short
         always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               grant_q <= 1'b0;
            end else if (clk_en_in) begin
               if (reload || !frame_in[f].running) begin
                  grant_q <= 1'b0;
               end else if (due_q && !frame_in[f].async_busy) begin
                  grant_q <= 1'b1; // RULE_05
               end
            end
         end

         always_comb begin
            frame_out[f].periodic_priority = due_q;
            frame_out[f].periodic_grant = grant_q;
            frame_out[f].remaining_bit_times = remaining_q;
            frame_out[f].frame_count = frame_q;
            frame_out[f].low_speed_start = 1'b0;
            frame_out[f].low_speed_deferred = 1'b0;
            if (frame_in[f].low_speed_request && frame_in[f].running) begin
               // compare against the low 12 bits only, upper limit bits are zero
               if (remaining_q >= {2'b00, lsc_q}) begin // RULE_07
                  frame_out[f].low_speed_start = 1'b1; // RULE_08
               end else begin
                  frame_out[f].low_speed_deferred = 1'b1; // RULE_08
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // read data mux, registered

   logic [31:0] rdata_d;
   logic hit_d;

   always_comb begin
      rdata_d = 32'h0000_0000;
      hit_d = 1'b0;
      for (int i = 0; i < functions; i++) begin
         rdata_d = rdata_d | rd_word[i];
         hit_d = hit_d | rd_hit[i];
      end
   end

   // unmapped offsets answer zero with reg_hit_out low
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= read_data_reset;
         reg_hit_out <= 1'b0;
      end else if (clk_en_in) begin
         reg_rdata_out <= rdata_d;
         reg_hit_out <= hit_d && reg_req_in.sel;
      end
   end

endmodule

// file: hdl/frame_gate_pkg.sv
// frame gate package: register map, reset values, field widths, carriers
// assumes one controller function per index, two functions in all
package frame_gate_pkg;

   localparam int num_functions = 2;
   localparam int offset_width = 8;
   localparam int psp_width = 14;
   localparam int lsc_width = 12;
   localparam int remaining_width = 14;
   localparam int frame_count_width = 16;

   // offsets inside each function's memory window
   localparam logic [offset_width-1:0] periodic_start_point_offset = 8'h40;
   localparam logic [offset_width-1:0] low_speed_commit_limit_offset = 8'h44;

   // values after reset
   localparam logic [psp_width-1:0] periodic_start_point_reset = 14'h0000;
   localparam logic [lsc_width-1:0] low_speed_commit_field_reset = 12'h628;
   localparam logic [remaining_width-1:0] remaining_reset = 14'h0000;
   localparam logic [frame_count_width-1:0] frame_count_reset = 16'h0000;
   localparam logic [31:0] read_data_reset = 32'h0000_0000;

   // register access request from the memory window decoder
   typedef struct packed {
      logic sel;
      logic func;
      logic write;
      logic [offset_width-1:0] offset;
      logic [31:0] wdata;
   } reg_req_t;

   // frame timing inputs of one function
   typedef struct packed {
      logic running;
      logic [remaining_width-1:0] interval_setting;
      logic async_busy;
      logic low_speed_request;
   } frame_in_t;

   // frame gate decisions of one function
   typedef struct packed {
      logic periodic_priority;
      logic periodic_grant;
      logic low_speed_start;
      logic low_speed_deferred;
      logic [remaining_width-1:0] remaining_bit_times;
      logic [frame_count_width-1:0] frame_count;
   } frame_out_t;

endpackage

// file: test/frame_gate_chk_assertions.sv
// checker: register decode and frame gate timing, function 0
// assumes it is bound onto the gate top and sees only its ports
`timescale 1ns/1ns
module frame_gate_chk
   import frame_gate_pkg::*;
#(parameter int functions = num_functions) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   // register access and frame timing
   input wire reg_req_t reg_req_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic reg_hit_out,
   input wire logic bit_tick_in,
   input wire frame_in_t [functions-1:0] frame_in,
   input wire frame_out_t [functions-1:0] frame_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   frame_in_t i;
   frame_out_t o;
   logic go, tk, map;
   assign i = frame_in[0];
   assign o = frame_out[0];
   assign go = clk_en_in && reg_req_in.sel;
   assign tk = clk_en_in && bit_tick_in && i.running;
   assign map = reg_req_in.offset inside {periodic_start_point_offset,
      low_speed_commit_limit_offset};
   property p_hit; go && map |=> reg_hit_out; endproperty
   a_hit: assert property (p_hit) else $error("mapped access gave no hit");
   property p_miss; go && !map |=> !reg_hit_out && reg_rdata_out == 32'h0000_0000; endproperty
   a_miss: assert property (p_miss) else $error("unmapped access answered");
   property p_rsv0;
      go && reg_req_in.offset == 8'h40 |=> reg_rdata_out[31:14] == 18'h0_0000;
   endproperty
   a_rsv0: assert property (p_rsv0) else $error("start point upper bits set");
   property p_rsv1;
      go && reg_req_in.offset == 8'h44 |=> reg_rdata_out[31:12] == 20'h0_0000;
   endproperty
   a_rsv1: assert property (p_rsv1) else $error("commit limit upper bits set");
   property p_load;
      tk && o.remaining_bit_times == 14'h0000 |=> o.remaining_bit_times ==
         $past(i.interval_setting) && o.frame_count == $past(o.frame_count) + 16'h0001;
   endproperty
   a_load: assert property (p_load) else $error("frame reload wrong");
   property p_dec;
      tk && o.remaining_bit_times != 14'h0000 |=>
         o.remaining_bit_times == $past(o.remaining_bit_times) - 14'h0001;
   endproperty
   a_dec: assert property (p_dec) else $error("countdown wrong");
   property p_ls;
      1'b1 |-> (o.low_speed_start || o.low_speed_deferred) ==
         (i.low_speed_request && i.running) && !(o.low_speed_start && o.low_speed_deferred);
   endproperty
   a_ls: assert property (p_ls) else $error("low-speed decision wrong");
   property p_busy; clk_en_in && i.async_busy && !o.periodic_grant |=> !o.periodic_grant;
   endproperty
   a_busy: assert property (p_busy) else $error("grant while busy");
endmodule
bind ohci_periodic_and_lowspeed_gate frame_gate_chk #(.functions(functions)) u_chk (.*);

// file: test/host_driver_model.sv
// host driver model: accesses through the memory window decoder port
// assumes the gate answers one cycle after an access is taken
`timescale 1ns/1ns
module host_driver_model
   import frame_gate_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic [31:0] rdata_in,
   input wire logic hit_in,
   output reg_req_t req_out
);
   initial req_out = '0;
   task automatic access(input logic fn, input logic wr, input logic [7:0] off,
         input logic [31:0] wd, output logic [31:0] rd, output logic hit);
      logic [31:0] m;
      m = off == 8'h40 ? 32'h0000_3fff : off == 8'h44 ? 32'h0000_0fff : 32'hffff_ffff;
      @(posedge sys_clk_in);
      req_out <= '{1'b1, fn, wr, off, wd & m};
      @(posedge sys_clk_in);
      req_out.sel <= 1'b0;
      #1;
      rd = rdata_in;
      hit = hit_in;
   endtask
   // loaded once at init, limit never touched again
   task automatic init(input logic fn, input logic [13:0] psp, input logic [11:0] lim);
      logic [31:0] r;
      logic h;
      access(fn, 1'b1, 8'h40, {18'h0_0000, psp}, r, h);
      access(fn, 1'b1, 8'h44, {20'h0_0000, lim}, r, h);
   endtask
endmodule

// file: test/tb.sv
// testbench: register map and frame gating of the frame gate
// assumes the host driver model and the bound checker
`timescale 1ns/1ns
module tb;
   import frame_gate_pkg::*;
   logic sys_clk_in, rst_n_in, bit_tick_in, hit, hs;
   logic clk_en = 1'b1;
   logic [31:0] rdata, rd;
   reg_req_t req;
   frame_in_t [1:0] fin;
   frame_out_t [1:0] fo;
   int errors = 0, total_checks = 0, cyc = 0;
   ohci_periodic_and_lowspeed_gate u_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
      .clk_en_in(clk_en), .reg_req_in(req), .reg_rdata_out(rdata), .reg_hit_out(hit),
      .bit_tick_in(bit_tick_in), .frame_in(fin), .frame_out(fo));
   host_driver_model u_host (.sys_clk_in(sys_clk_in), .rdata_in(rdata), .hit_in(hit),
      .req_out(req));
   initial begin
      sys_clk_in = 1'b0;
      forever #25 sys_clk_in = ~sys_clk_in;
   end
   // the whole run needs about 54 cycles
   always @(posedge sys_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors = errors + 1;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      total_checks++;
      if (got !== ex) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic rw(input logic fn, input logic wr, input logic [7:0] off, input logic [31:0] wd);
      u_host.access(fn, wr, off, wd, rd, hs);
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge sys_clk_in);
         bit_tick_in <= 1'b1;
         @(posedge sys_clk_in);
         bit_tick_in <= 1'b0;
      end
      #1;
   endtask
   task automatic results();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rw(0, 0, 8'h40, 0);
      chk("start reset", 32'h0000_0000, rd);
      chk("start hit", 32'h0000_0001, {31'h0, hs});
      rw(1, 0, 8'h44, 0);
      chk("limit reset", 32'h0000_0628, rd);
      rw(1, 1, 8'h40, 32'h0000_3e67);
      rw(1, 0, 8'h40, 0);
      chk("start f1", 32'h0000_3e67, rd);
      rw(0, 0, 8'h40, 0);
      chk("start f0 apart", 32'h0000_0000, rd);
      rw(0, 0, 8'h48, 0);
      chk("unmapped", 32'h0000_0000, {rd[31:1], hs});
      $display("t_regs done");
   endtask
   task automatic t_frame();
      u_host.init(0, 14'h0002, 12'h003);
      chk("ls early", 32'h0000_0001, {31'h0, fo[0].low_speed_deferred});
      tick(1);
      chk("reload", 32'h0001_0006, {fo[0].frame_count, 2'b00, fo[0].remaining_bit_times});
      tick(3);
      chk("ls at limit", 32'h0000_0001, {31'h0, fo[0].low_speed_start});
      chk("prio early", 32'h0000_0000, {31'h0, fo[0].periodic_priority});
      tick(1);
      chk("ls below", 32'h0000_0001, {31'h0, fo[0].low_speed_deferred});
      @(posedge sys_clk_in);
      fin[0].async_busy <= 1'b0;
      #1;
      chk("prio busy", 32'h0000_0002, {30'h0, fo[0].periodic_priority, fo[0].periodic_grant});
      repeat (2) @(posedge sys_clk_in);
      #1;
      chk("grant", 32'h0000_0003, {30'h0, fo[0].periodic_priority, fo[0].periodic_grant});
      tick(3);
      chk("next frame", 32'h0002_0006, {fo[0].frame_count, 1'b0, fo[0].periodic_priority,
         fo[0].remaining_bit_times});
      chk("idle f1", 32'h0000_0000, {18'h0, fo[1].remaining_bit_times});
      // enable low must freeze the countdown even with a bit tick
      @(posedge sys_clk_in);
      clk_en <= 1'b0;
      tick(1);
      chk("frozen", 32'h0002_0006, {fo[0].frame_count, 2'b00, fo[0].remaining_bit_times});
      clk_en <= 1'b1;
      $display("t_frame done");
   endtask
   initial begin
      rst_n_in = 1'b0;
      bit_tick_in = 1'b0;
      fin[0] = '{1'b1, 14'h0006, 1'b1, 1'b1};
      fin[1] = '0;
      repeat (16) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      t_regs();
      t_frame();
      results();
   end
endmodule
